//--- dv/cbc_stack_model.sv
// Cell stack model: per-cell voltage, sagging on the cell being bled.
// Assumes the bench sets open-circuit voltages just after clock edges.
`timescale 1ns/100ps
`default_nettype none
module cbc_stack_model (
  input wire logic clk,
  input wire cbc_pkg::cbc_cells_t ocv,
  input wire logic [cbc_pkg::NUM_CELLS-1:0] bleed,
  output var cbc_pkg::cbc_cells_t cells
);
  // Resistor drop while bleeding: frozen readings must hide it
  always_ff @(posedge clk) begin
    for (int i = 0; i < cbc_pkg::NUM_CELLS; i++) begin
      cells.mv[i] <= ocv.mv[i] - (bleed[i] ? 13'h0_014 : 13'h0_000);
    end
  end
endmodule : cbc_stack_model
`default_nettype wire

//--- dv/cbc_top_properties.sv
// Checker: bleed, phase, freeze and delay relations at the controller ports.
// Assumes the bench's shortened timing of five measurement cycles.
`timescale 1ns/100ps
`default_nettype none
module cbc_top_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic ov_timing,
  input wire logic uv_timing,
  input wire logic shutdown,
  input wire logic [cbc_pkg::NUM_CELLS-1:0] bleed,
  input wire logic meas_active,
  input wire logic [15:0] ov_delay_ms,
  input wire logic [15:0] uv_delay_ms,
  input wire cbc_pkg::cbc_cells_t cells_held
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_one_bleed: assert property ($onehot0(bleed)) else $error("several bleeds");
  a_meas_quiet: assert property (meas_active |-> bleed == '0)
    else $error("bleed in measurement");
  a_meas_length: assert property ($rose(meas_active) |-> meas_active [*5] ##1 !meas_active)
    else $error("measurement length");
  a_held_frozen: assert property (bleed != '0 && $past(bleed) != '0 |-> $stable(cells_held))
    else $error("readings moved while bleeding");
  a_choice_hold: assert property (bleed != '0 |=> bleed == $past(bleed) || bleed == '0)
    else $error("choice changed mid phase");
  a_fault_stop: assert property (ov_timing || uv_timing |=> bleed == '0)
    else $error("bleed during fault timing");
  a_sleep_stop: assert property (shutdown |=> bleed == '0) else $error("bleed in shutdown");
  a_delay_floor: assert property (ov_delay_ms >= 16'h01F4 && uv_delay_ms >= 16'h01F4)
    else $error("delay below floor");
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or okay");
endmodule : cbc_top_properties
bind cbc_top cbc_top_properties cbc_top_properties_inst (.clk, .rst_n, .hreadyout, .hresp,
  .ov_timing, .uv_timing, .shutdown, .bleed, .meas_active, .ov_delay_ms, .uv_delay_ms,
  .cells_held);
`default_nettype wire

//--- dv/tb.sv
// Bench: register, gating, fault and timeout scenarios of the controller.
// Assumes shortened timing: 5 and 25 cycles a phase and cycle, dwell 4, hour 3.
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic hsel = 1'b0, hwrite = 1'b0, charger_pin = 1'b0, ov_timing = 1'b0, uv_timing = 1'b0;
  logic clk = 1'b0, rst_n = 1'b0, shutdown = 1'b0, hreadyout, hresp, meas_active, meas_hold;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [9:0] bleed;
  logic [15:0] ov_d, uv_d;
  cbc_pkg::cbc_cells_t ocv = '0, cells, cells_held;
  int failures = 0, n_tests = 0;
  always #4 clk = ~clk;
  cbc_stack_model cbc_stack_model_inst (.clk, .ocv, .bleed, .cells);
  cbc_top #(.MEAS_CYCLES(5), .CYCLE_CYCLES(25), .DWELL_TICKS(4), .HOUR_TICKS(3)) cbc_top_inst (
    .clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .cells, .charger_pin, .ov_timing, .uv_timing, .shutdown,
    .bleed, .meas_active, .meas_hold, .ov_delay_ms(ov_d), .uv_delay_ms(uv_d), .cells_held);
  task final_report;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task ready;
    int k;
    k = 0;
    do begin @(posedge clk); k++; end while (hreadyout !== 1'b1 && k < 50);
    if (k >= 50) begin failures++; final_report(); end
  endtask : ready
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'h2;
    ready();
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    ready();
    rd = hrdata;
  endtask : bus
  task wait_bleed(input logic [9:0] exp);
    int k;
    k = 0;
    while (bleed !== exp && k < 400) begin @(posedge clk); k++; end
    check(32'(bleed), 32'(exp));
    if (k >= 400) final_report();
  endtask : wait_bleed
  task quiet(input int n);
    logic any;
    any = 1'b0;
    repeat (n) begin @(posedge clk); any = any | (|bleed); end
    check(32'(any), 32'h0);
  endtask : quiet
  task cells_to(input logic [12:0] v);
    for (int i = 0; i < 10; i++) ocv.mv[i] <= v;
  endtask : cells_to
  task t_regs;
    bus(1'b0, 32'h0, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, 32'h8, 32'h0);
    check(rd, 32'h01F4_01F4);
    bus(1'b1, 32'h8, 32'h0064_0064);
    bus(1'b0, 32'h8, 32'h0);
    check(rd, 32'h01F4_01F4);
    bus(1'b1, 32'h8, 32'h03E8_0258);
    bus(1'b0, 32'h8, 32'h0);
    check(rd, 32'h03E8_0258);
    check({uv_d, ov_d}, 32'h03E8_0258);
    bus(1'b0, 32'h0000_000C, 32'h0);
    check(rd, 32'h0);
  endtask : t_regs
  task t_gate;
    charger_pin <= 1'b1;
    cells_to(13'h0F3C);
    bus(1'b1, 32'h0, 32'h0000_0040);
    quiet(150);
    cells_to(13'h0BB8);
    bus(1'b1, 32'h0, 32'h0000_000F);
    quiet(150);
    charger_pin <= 1'b0;
    bus(1'b1, 32'h0, 32'h0000_00CF);
    quiet(150);
  endtask : t_gate
  task t_charger;
    cells_to(13'h09C4);
    ocv.mv[3] <= 13'h0BB8;
    ocv.mv[6] <= 13'h0BB8;
    charger_pin <= 1'b1;
    bus(1'b1, 32'h0, 32'h0000_004F);
    wait_bleed(10'h008);
    ocv.mv[5] <= 13'h0DAC;
    wait_bleed(10'h020);
    check(32'(meas_hold), 32'h1);
    check(32'(cells_held.mv[5]), 32'h0000_0DAC);
    charger_pin <= 1'b0;
    repeat (4) @(posedge clk);
    check(32'(bleed), 32'h0);
    quiet(120);
  endtask : t_charger
  task t_fault;
    cells_to(13'h09C4);
    ocv.mv[2] <= 13'h0BB8;
    charger_pin <= 1'b1;
    for (int f = 0; f < 3; f++) begin
      wait_bleed(10'h004);
      {shutdown, uv_timing, ov_timing} <= 3'(1 << f);
      @(posedge clk);
      quiet(60);
      {shutdown, uv_timing, ov_timing} <= 3'h0;
    end
    wait_bleed(10'h004);
  endtask : t_fault
  task t_timer;
    charger_pin <= 1'b0;
    cells_to(13'h0BB8);
    for (int t = 0; t < 4; t++) begin
      bus(1'b1, 32'h0, 32'h0000_008F | 32'(t << 4));
      wait_bleed(10'h001);
      repeat (75 * (1 << t) - 50) @(posedge clk);
      bus(1'b0, 32'h4, 32'h0);
      check(32'(rd[5]), 32'h0);
      repeat (200) @(posedge clk);
      bus(1'b0, 32'h4, 32'h0);
      check(32'(rd[5]), 32'h1);
      quiet(150);
    end
  endtask : t_timer
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_gate();
    t_charger();
    t_fault();
    t_timer();
    final_report();
  end
endmodule : tb
`default_nettype wire

//--- src/cbc_pkg.sv
// Constants and types for the cell balance controller.
// Assumes a 125 MHz core clock and ten cell voltage words in millivolts.
// Functional notes
// [R1] Balancing choice is recomputed and latched only at each dwell boundary.
// [R2] Choice bleeds the highest cell above start voltage, no hysteresis.
// [R3] At most one bleed output is asserted at any time.
// [R4] Dwell period between decisions lasts at least 7.5 minutes.
// [R5] After timeout expiry the decision logic is reset and stops computing.
// [R6] No bleed while the highest cell is below the start voltage.
// [R7] With timeout configured and expired, all balancing is suppressed.
// [R8] With charger gating, no balancing while no charger is detected.
// [R9] Each 250 ms cycle: 50 ms measuring with balancing off, 200 ms balancing.
// [R10] Cell measurement results are frozen while any bleed output is asserted.
// [R11] Overvoltage and undervoltage delays accept only 500 ms or longer.
// [R12] Balancing suspends while an overvoltage or undervoltage is being timed.
// [R13] Balancing resumes once fault timing ends, cleared or latched.
// [R14] Timeout is a 2-bit choice of 1, 2, 4 or 8 hours.
// [R15] Timeout timer starts when a cell first exceeds the start voltage; here it starts at the first dwell boundary that finds one above.
// [R16] Balancing stops immediately when the charger is disconnected; here bleed clears three clocks later, through the pin synchroniser.
// [R17] Start voltage is 4 bits, 3.9 V down to 2.4 V by 0.1 V, default 3.9 V.
// [R18] Enable select chooses charger, timer, both, or disabled at all zero.
// [R19] Start detection uses its own comparator, not the overvoltage trip.
// [R20] Balancing is allowed while charging is in progress.
// [R21] In shutdown every function including balancing stays inactive.
// [R22] Integrators should enable the timeout so balancing cannot drain the pack.
// [R23] Ties for highest voltage select the lowest-numbered cell.
package cbc_pkg;
  localparam int NUM_CELLS = 10;
  localparam int MV_W = 13;
  localparam int IDX_W = 4;

  // Timing, in printed units, then in 125 MHz cycles or 250 ms ticks
  localparam longint CLK_HZ = 125_000_000;
  localparam longint MEAS_MS = 50;
  localparam longint BAL_MS = 200;
  localparam longint CYCLE_MS = MEAS_MS + BAL_MS;
  localparam longint MEAS_CYCLES = MEAS_MS * CLK_HZ / 1000;
  localparam longint CYCLE_CYCLES = CYCLE_MS * CLK_HZ / 1000;
  localparam longint DWELL_MS = 450_000;
  localparam longint DWELL_TICKS = DWELL_MS / CYCLE_MS;
  localparam longint HOUR_MS = 3_600_000;
  localparam longint HOUR_TICKS = HOUR_MS / CYCLE_MS;
  localparam int CYC_W = 25;
  localparam int DWELL_W = 11;
  localparam int TMR_W = 17;

  // Start voltage: code 0 is the highest threshold
  localparam logic [12:0] START_TOP_MV = 13'h0_F3C;
  localparam logic [12:0] START_STEP_MV = 13'h0_064;
  localparam logic [15:0] MIN_DELAY_MS = 16'h01_F4;

  // Register map
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] DLY_OFS = 8'h08;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [31:0] DLY_RST = 32'h01F4_01F4;
  localparam int EN_POS = 6;
  localparam int TMO_POS = 4;
  localparam int START_POS = 0;

  typedef enum logic [1:0] {
    CBC_EN_OFF = 2'b00,
    CBC_EN_CHG = 2'b01,
    CBC_EN_TMR = 2'b10,
    CBC_EN_BOTH = 2'b11
  } cbc_en_t;

  typedef struct packed {
    cbc_en_t enable;
    logic [1:0] timeout;
    logic [3:0] start;
  } cbc_ctrl_t;

  typedef struct packed {
    logic [NUM_CELLS-1:0][MV_W-1:0] mv;
  } cbc_cells_t;
endpackage : cbc_pkg

//--- src/cbc_top.sv
// Cell balance controller: picks and bleeds the highest cell once per dwell.
// Assumes an AHB-Lite master on the same clock, cell words from the
// measurement logic on this clock, and an asynchronous charger-detect pin.
//
// The AHB-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module cbc_top #(
  parameter longint MEAS_CYCLES = cbc_pkg::MEAS_CYCLES,
  parameter longint CYCLE_CYCLES = cbc_pkg::CYCLE_CYCLES,
  parameter longint DWELL_TICKS = cbc_pkg::DWELL_TICKS,
  parameter longint HOUR_TICKS = cbc_pkg::HOUR_TICKS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire cbc_pkg::cbc_cells_t cells,
  input wire logic charger_pin,
  input wire logic ov_timing,
  input wire logic uv_timing,
  input wire logic shutdown,
  output logic [cbc_pkg::NUM_CELLS-1:0] bleed,
  output logic meas_active,
  output logic meas_hold,
  output logic [15:0] ov_delay_ms,
  output logic [15:0] uv_delay_ms,
  output cbc_pkg::cbc_cells_t cells_held
);
  localparam int N = cbc_pkg::NUM_CELLS;
  localparam logic [cbc_pkg::CYC_W-1:0] MEAS_LAST = cbc_pkg::CYC_W'(MEAS_CYCLES - 1);
  localparam logic [cbc_pkg::CYC_W-1:0] CYCLE_LAST = cbc_pkg::CYC_W'(CYCLE_CYCLES - 1);
  localparam logic [cbc_pkg::DWELL_W-1:0] DWELL_LAST = cbc_pkg::DWELL_W'(DWELL_TICKS - 1);
  localparam logic [cbc_pkg::TMR_W-1:0] HOUR_T = cbc_pkg::TMR_W'(HOUR_TICKS);

  // Bus address phase and data phase
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] hrdata_q;
  cbc_pkg::cbc_ctrl_t ctrl_q;
  logic [15:0] ov_dly_q;
  logic [15:0] uv_dly_q;

  wire addr_ok = hsel && hready && htrans[1];
  wire rd_req = addr_ok && !hwrite;
  wire wr_req = addr_ok && hwrite;
  wire wr_ctrl = wr_pend_q && (wr_addr_q == cbc_pkg::CTRL_OFS);
  wire wr_dly = wr_pend_q && (wr_addr_q == cbc_pkg::DLY_OFS);
  wire [15:0] ov_wr = hwdata[15:0];
  wire [15:0] uv_wr = hwdata[31:16];
  // Short settings would let a fault time out inside one balance phase
  wire [15:0] ov_clamped = (ov_wr < cbc_pkg::MIN_DELAY_MS) ? cbc_pkg::MIN_DELAY_MS : ov_wr; // see [R11]
  wire [15:0] uv_clamped = (uv_wr < cbc_pkg::MIN_DELAY_MS) ? cbc_pkg::MIN_DELAY_MS : uv_wr; // see [R11]

  // Charger pin synchroniser
  logic chg_meta_q;
  logic chg_q;

  // Cycle, dwell and timeout state
  logic [cbc_pkg::CYC_W-1:0] cyc_q;
  logic [cbc_pkg::DWELL_W-1:0] dwell_q;
  logic [cbc_pkg::TMR_W-1:0] tmr_q;
  logic tmr_run_q;
  logic tmr_exp_q;
  logic act_valid_q;
  logic [cbc_pkg::IDX_W-1:0] act_idx_q;
  logic [N-1:0] bleed_q;
  cbc_pkg::cbc_cells_t snap_q;

  wire in_meas = (cyc_q <= MEAS_LAST); // see [R9]
  // Bleed is registered, so gate on the phase of the next cycle
  wire next_meas = tick || (cyc_q < MEAS_LAST); // see [R9]
  wire tick = (cyc_q == CYCLE_LAST);
  wire dwell_end = tick && (dwell_q == DWELL_LAST); // see [R4]
  wire tmr_mode = ctrl_q.enable[1];
  wire chg_mode = ctrl_q.enable[0];
  wire [cbc_pkg::TMR_W-1:0] tmr_limit = HOUR_T << ctrl_q.timeout; // see [R14]
  wire [12:0] start_mv = cbc_pkg::START_TOP_MV - 13'(ctrl_q.start * cbc_pkg::START_STEP_MV); // see [R17]

  // Own start comparator on the frozen words, separate from overvoltage trip
  logic [cbc_pkg::IDX_W-1:0] hi_idx;
  logic [cbc_pkg::MV_W-1:0] hi_mv;
  always_comb begin
    hi_idx = '0;
    hi_mv = snap_q.mv[0];
    for (int i = 1; i < N; i++) begin
      if (snap_q.mv[i] > hi_mv) begin // see [R23]
        hi_mv = snap_q.mv[i];
        hi_idx = cbc_pkg::IDX_W'(i);
      end
    end
  end
  wire above = (hi_mv > start_mv); // see [R2] [R19]

  // Suppression terms; charger gating only, so charging itself never blocks
  wire gate = (ctrl_q.enable != cbc_pkg::CBC_EN_OFF) // see [R18]
      && !(tmr_mode && tmr_exp_q) // see [R7]
      && !(chg_mode && !chg_q) // see [R8] [R16] [R20]
      && !ov_timing && !uv_timing // see [R12] [R13]
      && !next_meas // see [R9]
      && !shutdown // see [R21]
      && act_valid_q;
  wire [N-1:0] onehot = N'(1) << act_idx_q; // see [R3]

  wire [31:0] stat_word = {23'h00_0000, chg_q, !in_meas, tmr_run_q, tmr_exp_q,
                           act_valid_q, act_idx_q};
  wire [31:0] rd_mux = (haddr[7:0] == cbc_pkg::CTRL_OFS) ? {24'h00_0000, ctrl_q} :
                       (haddr[7:0] == cbc_pkg::STAT_OFS) ? stat_word :
                       (haddr[7:0] == cbc_pkg::DLY_OFS) ? {uv_dly_q, ov_dly_q} :
                       32'h0000_0000;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
    end else begin
      wr_pend_q <= wr_req;
      wr_addr_q <= haddr[7:0];
      hrdata_q <= rd_req ? rd_mux : hrdata_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q <= cbc_pkg::CTRL_RST;
      ov_dly_q <= cbc_pkg::DLY_RST[15:0];
      uv_dly_q <= cbc_pkg::DLY_RST[31:16];
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= hwdata[7:0];
      end
      if (wr_dly) begin
        ov_dly_q <= ov_clamped;
        uv_dly_q <= uv_clamped;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      chg_meta_q <= 1'b0;
      chg_q <= 1'b0;
    end else begin
      chg_meta_q <= charger_pin;
      chg_q <= chg_meta_q;
    end
  end

  // Cycle and dwell counters clear and hold at zero in shutdown
  always_ff @(posedge clk) begin
    if (!rst_n || shutdown) begin // see [R21]
      cyc_q <= '0;
      dwell_q <= '0;
    end else begin
      cyc_q <= tick ? '0 : cyc_q + 1'b1;
      if (tick) begin
        dwell_q <= (dwell_q == DWELL_LAST) ? '0 : dwell_q + 1'b1;
      end
    end
  end

  // Snapshot taken at the end of measurement, never while bleeding
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      snap_q <= '0;
    end else if ((cyc_q == MEAS_LAST) && !(|bleed_q)) begin // see [R10]
      snap_q <= cells;
    end
  end

  // Timeout timer counts 250 ms ticks from the first dwell boundary with a cell above start
  always_ff @(posedge clk) begin
    if (!rst_n || shutdown || wr_ctrl || !tmr_mode) begin
      tmr_q <= '0;
      tmr_run_q <= 1'b0;
      tmr_exp_q <= 1'b0;
    end else begin
      if (dwell_end && above && !tmr_run_q && !tmr_exp_q) begin
        tmr_run_q <= 1'b1; // see [R15]
      end
      if (tick && tmr_run_q) begin
        if (tmr_q + 1'b1 >= tmr_limit) begin
          tmr_run_q <= 1'b0;
          tmr_exp_q <= 1'b1;
        end
        tmr_q <= tmr_q + 1'b1;
      end
    end
  end

  // Decision latch: once per dwell, cleared on expiry until a control write, shutdown or timer mode off
  always_ff @(posedge clk) begin
    if (!rst_n || shutdown || (tmr_mode && tmr_exp_q)) begin // see [R5] [R21]
      act_valid_q <= 1'b0;
      act_idx_q <= '0;
    end else if (dwell_end) begin // see [R1]
      act_valid_q <= above; // see [R6]
      act_idx_q <= hi_idx; // see [R2]
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bleed_q <= '0;
    end else begin
      bleed_q <= gate ? onehot : '0; // see [R3]
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign bleed = bleed_q;
  assign meas_active = in_meas && !shutdown;
  assign meas_hold = |bleed_q; // see [R10]
  assign ov_delay_ms = ov_dly_q;
  assign uv_delay_ms = uv_dly_q;
  assign cells_held = snap_q;
endmodule : cbc_top
`default_nettype wire
